// ---- core/wpp_protect.sv ----
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - two-bit scheme field, 00 disables, anything else enables, resets to 11
// - scheme field changes only when the same write carries key 11000
// - key 10011 opens writes to all protected bits
// - key 10101 closes writes to protected bits at once
// - any other key value changes nothing
// - read-only status bit 2 reads 1 when protected writes are blocked
// - open and close keys act only while the scheme field is 11
// - open window lasts at most 32 core clocks, then closes itself
// - a repeated open key restarts the 32-cycle window
// - write-allow output gates divider, watchdog, power-down and slow-down bits
module wpp_protect
    import wpp_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire wpp_bus_req_t bus_req,
    output var  logic [7:0]   rdata,
    output var  logic         write_allow,
    output var  logic         protect_status
);
    logic [1:0]  mode_reg;
    wpp_state_t  state_reg;
    logic [5:0]  count_reg;
    logic        key_hit;
    logic [4:0]  pass;
    logic [1:0]  mode_wdata;
    logic        mode_on;
    logic        open_key;
    logic        close_key;
    logic        blocked;

    // decode the key write
    assign key_hit   = bus_req.wr && (bus_req.addr == WPP_KEY_OFFSET);
    assign pass      = bus_req.wdata[WPP_PASS_MSB:WPP_PASS_LSB];
    assign mode_wdata = bus_req.wdata[WPP_MODE_MSB:WPP_MODE_LSB]; // new scheme value carried by a key write
    assign mode_on   = (mode_reg == WPP_MODE_RESET);
    assign open_key  = key_hit && mode_on && (pass == WPP_KEY_OPEN);
    assign close_key = key_hit && mode_on && (pass == WPP_KEY_CLOSE);

    // scheme-control field, only loaded together with the mode key
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            mode_reg <= WPP_MODE_RESET;
        else if (key_hit && pass == WPP_KEY_MODE)
            mode_reg <= mode_wdata;
    end

    // open window state and its countdown
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_reg <= WPP_CLOSED;
            count_reg <= 6'h00;
        end
        else
        begin
            case (state_reg)
                WPP_CLOSED:
                begin
                    if (open_key)
                    begin
                        state_reg <= WPP_OPEN;
                        count_reg <= WPP_WINDOW_LOAD;
                    end
                end
                WPP_OPEN:
                begin
                    if (close_key || !mode_on)
                    begin
                        state_reg <= WPP_CLOSED;
                        count_reg <= 6'h00;
                    end
                    else if (open_key)
                        count_reg <= WPP_WINDOW_LOAD;
                    else if (count_reg == 6'h01)
                    begin
                        state_reg <= WPP_CLOSED;
                        count_reg <= 6'h00;
                    end
                    else
                        count_reg <= count_reg - 6'h01;
                end
                default:
                    state_reg <= WPP_CLOSED;
            endcase
        end
    end

    // blocked only when the scheme is on and no window is open
    assign blocked = (mode_reg != WPP_MODE_OFF) && (state_reg != WPP_OPEN);

    // registered outputs for the protected-bit owners
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            write_allow    <= 1'b0;
            protect_status <= 1'b1;
        end
        else
        begin
            write_allow    <= !blocked;
            protect_status <= blocked;
        end
    end

    // read data one cycle after the strobe; pass field reads as zero
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (bus_req.rd && bus_req.addr == WPP_KEY_OFFSET)
            rdata <= {5'h00, blocked, mode_reg};
        else
            rdata <= 8'h00;
    end

    // assertions
    sequence s_open_write;
        open_key && state_reg == WPP_CLOSED;
    endsequence

    property p_mode_reset;
        @(posedge clk_sys) $rose(rst_n) |-> mode_reg == WPP_MODE_RESET;
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("scheme field not 11 after reset");

    property p_mode_guard;
        @(posedge clk_sys) disable iff (!rst_n)
        !(key_hit && pass == WPP_KEY_MODE) |=> $stable(mode_reg);
    endproperty
    a_mode_guard: assert property (p_mode_guard) else $error("scheme field changed without key");

    property p_open;
        @(posedge clk_sys) disable iff (!rst_n)
        s_open_write |-> ##2 write_allow && !protect_status;
    endproperty
    a_open: assert property (p_open) else $error("open key did not allow writes");

    property p_close;
        @(posedge clk_sys) disable iff (!rst_n)
        close_key |-> ##2 !write_allow && protect_status;
    endproperty
    a_close: assert property (p_close) else $error("close key did not block writes");

    property p_other_key;
        @(posedge clk_sys) disable iff (!rst_n)
        key_hit && pass != WPP_KEY_OPEN && pass != WPP_KEY_CLOSE && pass != WPP_KEY_MODE
        |=> $stable(mode_reg) && (state_reg == WPP_CLOSED || count_reg != WPP_WINDOW_LOAD);
    endproperty
    a_other_key: assert property (p_other_key) else $error("unknown key changed state");

    property p_status_read;
        @(posedge clk_sys) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == WPP_KEY_OFFSET |=> rdata[WPP_STATUS_BIT] == protect_status;
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bit mismatch");

    property p_gate_mode;
        @(posedge clk_sys) disable iff (!rst_n)
        key_hit && !mode_on |=> $stable(state_reg) || state_reg == WPP_CLOSED;
    endproperty
    a_gate_mode: assert property (p_gate_mode) else $error("key acted with scheme not 11");

    property p_window;
        @(posedge clk_sys) disable iff (!rst_n)
        s_open_write ##1 (!key_hit && mode_on) [*8] |-> state_reg == WPP_OPEN && count_reg == WPP_WINDOW_LOAD - 6'h07;
    endproperty
    a_window: assert property (p_window) else $error("window count wrong");

    property p_restart;
        @(posedge clk_sys) disable iff (!rst_n)
        open_key && state_reg == WPP_OPEN && !close_key |=> count_reg == WPP_WINDOW_LOAD;
    endproperty
    a_restart: assert property (p_restart) else $error("window not restarted");

    property p_disabled;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_reg == WPP_MODE_OFF |=> write_allow && !protect_status;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled scheme still blocks");

    // a key write that reloads the scheme field
    sequence s_mode_write;
        key_hit && pass == WPP_KEY_MODE;
    endsequence

    property p_mode_write;
        @(posedge clk_sys) disable iff (!rst_n)
        s_mode_write |=> mode_reg == $past(mode_wdata);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("scheme field not loaded by key");

    // the window closes itself when the count runs out
    property p_expire;
        @(posedge clk_sys) disable iff (!rst_n)
        state_reg == WPP_OPEN && count_reg == 6'h01 && !open_key |=> state_reg == WPP_CLOSED;
    endproperty
    a_expire: assert property (p_expire) else $error("window did not close at end of count");

    // an open window never holds an empty or oversized count
    property p_count_range;
        @(posedge clk_sys) disable iff (!rst_n)
        state_reg == WPP_OPEN |-> count_reg != 6'h00 && count_reg <= WPP_WINDOW_LOAD;
    endproperty
    a_count_range: assert property (p_count_range) else $error("window count out of range");

    // enabled scheme with a closed window keeps the protected bits locked
    property p_allow_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_reg != WPP_MODE_OFF && state_reg == WPP_CLOSED |=> !write_allow && protect_status;
    endproperty
    a_allow_gate: assert property (p_allow_gate) else $error("write allowed while locked");

    // outputs sit at their locked values right after reset
    property p_reset_out;
        @(posedge clk_sys) !rst_n |=> !write_allow && protect_status && rdata == 8'h00;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not locked after reset");

    // the key field is write-only and reads back as zero
    property p_key_reads_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        bus_req.rd |=> rdata[WPP_PASS_MSB:WPP_PASS_LSB] == 5'h00;
    endproperty
    a_key_reads_zero: assert property (p_key_reads_zero) else $error("key field read back nonzero");
endmodule : wpp_protect
`default_nettype wire

// ---- core/wpp_pkg.sv ----
`default_nettype none
package wpp_pkg;
    // field positions of the protection key register
    localparam int        WPP_MODE_LSB      = 0;
    localparam int        WPP_MODE_MSB      = 1;
    localparam int        WPP_STATUS_BIT    = 2;
    localparam int        WPP_PASS_LSB      = 3;
    localparam int        WPP_PASS_MSB      = 7;
    // register offset of the protection key register (chosen)
    localparam logic [7:0] WPP_KEY_OFFSET   = 8'h00;
    // reset value of the scheme-control field
    localparam logic [1:0] WPP_MODE_RESET   = 2'h3;
    localparam logic [1:0] WPP_MODE_OFF     = 2'h0;
    // key patterns
    localparam logic [4:0] WPP_KEY_MODE     = 5'h18;
    localparam logic [4:0] WPP_KEY_OPEN     = 5'h13;
    localparam logic [4:0] WPP_KEY_CLOSE    = 5'h15;
    // open window length in core clock cycles
    localparam int         WPP_WINDOW_CYC   = 32;
    localparam logic [5:0] WPP_WINDOW_LOAD  = 6'(WPP_WINDOW_CYC);

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } wpp_bus_req_t;

    typedef enum logic {WPP_CLOSED, WPP_OPEN} wpp_state_t;
endpackage : wpp_pkg
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import wpp_pkg::*;
;
    logic         clk_sys;
    logic         rst_n;
    wpp_bus_req_t bus_req;
    logic [7:0]   rdata;
    logic         write_allow;
    logic         protect_status;
    logic [7:0]   exp_q[$];
    logic         rd_seen = 1'b0;
    logic [31:0]  seed;
    int           failures;
    int           check_count;

    wpp_protect wpp_protect_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
        .write_allow(write_allow), .protect_status(protect_status));

    // free-running core clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
    endfunction : lfsr

    task automatic end_sim;
        if (exp_q.size() != 0) failures++;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp

    // one bus cycle per call, so no signal is assigned twice at one edge
    task automatic op(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask : op

    task automatic idle(input int n);
        repeat (n) op(8'h00, 8'h00, 1'b0, 1'b0);
    endtask : idle

    task automatic wr(input logic [7:0] d);
        op(WPP_KEY_OFFSET, d, 1'b1, 1'b0);
    endtask : wr

    // expected read byte is queued for the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        op(a, 8'h00, 1'b0, 1'b1);
    endtask : rd

    task automatic flags(input logic allow);
        #1;
        cmp("write_allow", {7'h00, allow}, {7'h00, write_allow});
        cmp("protect_status", {7'h00, !allow}, {7'h00, protect_status});
    endtask : flags

    // read data stand one cycle after the sampled read strobe
    always @(posedge clk_sys)
    begin
        if (rd_seen)
            cmp("rdata", exp_q.pop_front(), rdata);
        rd_seen <= rst_n && bus_req.rd;
    end

    // main sequence
    initial
    begin
        logic [7:0] d;
        rst_n = 1'b0;
        bus_req = '0;
        seed = 32'hAA810E6F;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        flags(1'b0);
        rd(WPP_KEY_OFFSET, 8'h07);
        $display("test reset done");
        wr(8'h98);
        rd(WPP_KEY_OFFSET, 8'h03);
        idle(32);
        flags(1'b1);
        idle(1);
        flags(1'b0);
        rd(WPP_KEY_OFFSET, 8'h07);
        $display("test window done");
        wr(8'h9B);
        idle(20);
        wr(8'h9B);
        idle(33);
        flags(1'b1);
        idle(1);
        flags(1'b0);
        $display("test restart done");
        wr(8'h9B);
        idle(5);
        flags(1'b1);
        wr(8'hAB);
        rd(WPP_KEY_OFFSET, 8'h07);
        idle(2);
        flags(1'b0);
        $display("test close done");
        // random values with no valid key, then an open key at a foreign address
        repeat (8)
        begin
            seed = lfsr(seed);
            d = seed[7:0];
            if (d[7:3] == WPP_KEY_MODE || d[7:3] == WPP_KEY_OPEN || d[7:3] == WPP_KEY_CLOSE) d[3] = ~d[3];
            wr(d);
        end
        op(8'h5A, 8'h9B, 1'b1, 1'b0);
        rd(8'h5A, 8'h00);
        rd(WPP_KEY_OFFSET, 8'h07);
        idle(2);
        flags(1'b0);
        $display("test foreign done");
        wr(8'hC0);
        rd(WPP_KEY_OFFSET, 8'h00);
        idle(2);
        flags(1'b1);
        wr(8'hA8);
        idle(3);
        flags(1'b1);
        wr(8'hC1);
        wr(8'h99);
        rd(WPP_KEY_OFFSET, 8'h05);
        idle(2);
        flags(1'b0);
        wr(8'hC3);
        wr(8'h9B);
        rd(WPP_KEY_OFFSET, 8'h03);
        idle(2);
        flags(1'b1);
        wr(8'hC2);
        idle(1); // the open window needs one cycle to close after leaving 11
        rd(WPP_KEY_OFFSET, 8'h06);
        idle(2);
        flags(1'b0);
        $display("test scheme done");
        idle(3);
        end_sim;
    end

    // watchdog, about four times the expected run
    initial
    begin
        #3000;
        failures++;
        end_sim;
    end
endmodule : tb_top
`default_nettype wire
